// ### flash_status_params.svh
// Constants for the flash status polling controller
`ifndef FLASH_STATUS_PARAMS_SVH
`define FLASH_STATUS_PARAMS_SVH

// Data bus bit positions of the status flags
`define POLL_BIT_POS 7
`define TOGGLE_BIT_POS 6
`define TIMEOUT_BIT_POS 5
`define SECTOR_TOGGLE_BIT_POS 2

// Reset command value written on the data bus
`define RESET_CMD 16'h00F0

// Bus cycle timing in nanoseconds and clock period
`define CLK_PERIOD_NS 20
`define STROBE_NS 60
`define STROBE_CYC ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_NS 40
`define GAP_CYC ((`GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### flash_status_pkg.sv
// Types for the flash status polling controller
package flash_status_pkg;

   typedef enum logic [1:0] {
      MODE_TOGGLE = 2'h0,
      MODE_POLL = 2'h1
   } poll_mode_t;

   typedef enum logic [1:0] {
      RESULT_NONE = 2'h0,
      RESULT_DONE = 2'h1,
      RESULT_FAIL = 2'h2
   } result_t;

endpackage

// ### flash_bus_cycle.sv
// One read or write cycle on the flash pins, with strobe and recovery timing
`include "flash_status_params.svh"

module flash_bus_cycle #(
   parameter int ADDR_W = 23,
   parameter int DATA_W = 16
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic start_i,
   input wire logic write_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   output logic busy_o,
   output logic done_o,
   output logic [DATA_W-1:0] rdata_o,
   output logic [ADDR_W-1:0] addr_o,
   output logic chip_sel_n_o,
   output logic out_en_n_o,
   output logic write_n_o,
   output logic [DATA_W-1:0] data_o,
   output logic data_oe_o,
   input wire logic [DATA_W-1:0] data_i
);

   localparam logic [3:0] STROBE_CNT = 4'(`STROBE_CYC);
   localparam logic [3:0] GAP_CNT = 4'(`GAP_CYC);

   typedef enum logic [1:0] {
      CYC_IDLE = 2'b00,
      CYC_STROBE = 2'b01,
      CYC_GAP = 2'b11
   } cyc_state_t;

   cyc_state_t state_q;
   logic [3:0] cnt_q;
   logic write_q;
   logic done_q;
   logic [DATA_W-1:0] rdata_q;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] wdata_q;
   wire cnt_zero = (cnt_q == 4'h0);

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_q <= CYC_IDLE;
         cnt_q <= 4'h0;
         write_q <= 1'b0;
         done_q <= 1'b0;
         rdata_q <= '0;
         addr_q <= '0;
         wdata_q <= '0;
      end else begin
         done_q <= 1'b0;
         unique case (state_q)
            CYC_IDLE: begin
               if (start_i) begin
                  state_q <= CYC_STROBE;
                  cnt_q <= STROBE_CNT - 4'h1;
                  write_q <= write_i;
                  addr_q <= addr_i;
                  wdata_q <= wdata_i;
               end
            end
            CYC_STROBE: begin
               if (cnt_zero) begin
                  // Sample read data just before the strobe rises
                  if (!write_q) begin
                     rdata_q <= data_i;
                  end
                  state_q <= CYC_GAP;
                  cnt_q <= GAP_CNT - 4'h1;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            CYC_GAP: begin
               if (cnt_zero) begin
                  state_q <= CYC_IDLE;
                  done_q <= 1'b1;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
         endcase
      end
   end

   // Each cycle ends with a rising strobe, so every read is a distinct cycle
   assign busy_o = (state_q != CYC_IDLE);
   assign done_o = done_q;
   assign rdata_o = rdata_q;
   assign addr_o = addr_q;
   assign chip_sel_n_o = (state_q != CYC_STROBE);
   assign out_en_n_o = !((state_q == CYC_STROBE) && !write_q);
   assign write_n_o = !((state_q == CYC_STROBE) && write_q);
   assign data_o = wdata_q;
   assign data_oe_o = write_q && (state_q != CYC_IDLE);

endmodule

// ### flash_status_poller.sv
// Host controller that polls flash program and erase status and aborts on failure
// Behaviour
// - Host reads status at programmed address
// - Erase status read inside chosen sector
// - Reread after polling match for full word
// - Two reads; no toggle means finished
// - Toggling with timeout: recheck, else reset
// - Restart from double read after pause
// - Recheck polling bit after timeout seen
// - Status reads target the busy bank
`include "flash_status_params.svh"

module flash_status_poller #(
   parameter int ADDR_W = 23,
   parameter int DATA_W = 16
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic start_i,
   input wire logic abandon_i,
   input wire flash_status_pkg::poll_mode_t mode_i,
   input wire logic [ADDR_W-1:0] status_addr_i,
   input wire logic [DATA_W-1:0] expect_data_i,
   output logic busy_o,
   output logic done_o,
   output flash_status_pkg::result_t result_o,
   output logic [DATA_W-1:0] final_data_o,
   output logic sector_erasing_o,
   output logic device_ready_o,
   output logic [ADDR_W-1:0] flash_addr_o,
   output logic flash_chip_sel_n_o,
   output logic flash_out_en_n_o,
   output logic flash_write_n_o,
   output logic [DATA_W-1:0] flash_data_o,
   output logic flash_data_oe_o,
   input wire logic [DATA_W-1:0] flash_data_i,
   input wire logic ready_busy_output_i
);

   // ************************************************************
   // State
   // ************************************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_FIRST = 3'b001,
      ST_SECOND = 3'b011,
      ST_RECHECK = 3'b010,
      ST_FINAL = 3'b110,
      ST_ABORT = 3'b111,
      ST_REPORT = 3'b101
   } poll_state_t;

   poll_state_t state_q;
   poll_state_t state_d;
   flash_status_pkg::poll_mode_t mode_q;
   flash_status_pkg::result_t result_q;
   flash_status_pkg::result_t result_d;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] expect_q;
   logic [DATA_W-1:0] prev_q;
   logic [DATA_W-1:0] final_q;
   logic sector_q;
   logic issued_q;
   logic ready_q;

   // ************************************************************
   // Bus cycle engine
   // ************************************************************
   logic cyc_busy;
   logic cyc_done;
   logic [DATA_W-1:0] cyc_rdata;
   wire cyc_write = (state_q == ST_ABORT);
   wire cyc_start = !issued_q && !cyc_busy && (state_q != ST_IDLE) && (state_q != ST_REPORT);

   flash_bus_cycle #(
      .ADDR_W(ADDR_W),
      .DATA_W(DATA_W)
   ) u_cycle (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .start_i(cyc_start),
      .write_i(cyc_write),
      .addr_i(addr_q),
      .wdata_i(`RESET_CMD),
      .busy_o(cyc_busy),
      .done_o(cyc_done),
      .rdata_o(cyc_rdata),
      .addr_o(flash_addr_o),
      .chip_sel_n_o(flash_chip_sel_n_o),
      .out_en_n_o(flash_out_en_n_o),
      .write_n_o(flash_write_n_o),
      .data_o(flash_data_o),
      .data_oe_o(flash_data_oe_o),
      .data_i(flash_data_i)
   );

   // ************************************************************
   // Status decode
   // ************************************************************
   function automatic logic toggled(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
      toggled = a[`TOGGLE_BIT_POS] != b[`TOGGLE_BIT_POS];
   endfunction

   // polling compare: inverted bit means still programming
   wire poll_match = (cyc_rdata[`POLL_BIT_POS] == expect_q[`POLL_BIT_POS]);
   wire timeout_seen = cyc_rdata[`TIMEOUT_BIT_POS];
   wire toggling = toggled(prev_q, cyc_rdata);
   wire is_poll = (mode_q == flash_status_pkg::MODE_POLL);
   // sector toggle flips only inside chosen sectors
   wire sector_flip = prev_q[`SECTOR_TOGGLE_BIT_POS] != cyc_rdata[`SECTOR_TOGGLE_BIT_POS];
   wire op_done = is_poll ? poll_match : !toggling;

   always_comb begin
      state_d = state_q;
      result_d = result_q;
      unique case (state_q)
         ST_IDLE: begin
            if (start_i) begin
               // every start begins at the first read
               state_d = ST_FIRST;
               result_d = flash_status_pkg::RESULT_NONE;
            end
         end
         ST_FIRST: begin
            if (cyc_done) begin
               state_d = ST_SECOND;
            end
         end
         ST_SECOND: begin
            if (cyc_done) begin
               // finished: no toggle between two reads in toggle mode, or the polling bit matches in poll mode
               if (op_done) begin
                  state_d = ST_FINAL;
               end else if (timeout_seen) begin
                  // timeout seen, check status once more
                  state_d = ST_RECHECK;
               end else if (abandon_i) begin
                  state_d = ST_IDLE;
               end else begin
                  state_d = ST_SECOND;
               end
            end
         end
         ST_RECHECK: begin
            if (cyc_done) begin
               if (op_done) begin
                  state_d = ST_FINAL;
               end else begin
                  // still busy after timeout: reset the device
                  state_d = ST_ABORT;
               end
            end
         end
         ST_FINAL: begin
            // one more read for a valid full word
            if (cyc_done) begin
               state_d = ST_REPORT;
               result_d = flash_status_pkg::RESULT_DONE;
            end
         end
         ST_ABORT: begin
            if (cyc_done) begin
               state_d = ST_REPORT;
               result_d = flash_status_pkg::RESULT_FAIL;
            end
         end
         ST_REPORT: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_q <= ST_IDLE;
         mode_q <= flash_status_pkg::MODE_TOGGLE;
         result_q <= flash_status_pkg::RESULT_NONE;
         addr_q <= '0;
         expect_q <= '0;
         prev_q <= '0;
         final_q <= '0;
         sector_q <= 1'b0;
         issued_q <= 1'b0;
         ready_q <= 1'b1;
      end else begin
         state_q <= state_d;
         result_q <= result_d;
         ready_q <= ready_busy_output_i;
         if (cyc_start) begin
            issued_q <= 1'b1;
         end else if (cyc_done) begin
            issued_q <= 1'b0;
         end
         if (state_q == ST_IDLE && start_i) begin
            // reads go to the caller's status address
            addr_q <= status_addr_i;
            expect_q <= expect_data_i;
            mode_q <= mode_i;
            sector_q <= 1'b0;
         end
         if (cyc_done && !cyc_write) begin
            prev_q <= cyc_rdata;
            if (state_q != ST_FIRST) begin
               sector_q <= sector_flip;
            end
            if (state_q == ST_FINAL) begin
               final_q <= cyc_rdata;
            end
         end
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign busy_o = (state_q != ST_IDLE);
   assign done_o = (state_q == ST_REPORT);
   assign result_o = result_q;
   assign final_data_o = final_q;
   assign sector_erasing_o = sector_q;
   // pin pulled high when no device drives it low
   assign device_ready_o = ready_q;

endmodule

// ### flash_poller_properties.sv
// Checker of the status poller pin and result behaviour
module flash_poller_properties #(
   parameter int ADDR_W = 23,
   parameter int DATA_W = 16
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic start_i,
   input wire logic [ADDR_W-1:0] status_addr_i,
   input wire logic busy_o,
   input wire logic done_o,
   input wire flash_status_pkg::result_t result_o,
   input wire logic device_ready_o,
   input wire logic [ADDR_W-1:0] flash_addr_o,
   input wire logic flash_chip_sel_n_o,
   input wire logic flash_out_en_n_o,
   input wire logic flash_write_n_o,
   input wire logic [DATA_W-1:0] flash_data_o,
   input wire logic flash_data_oe_o,
   input wire logic ready_busy_output_i
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   start_busy_a: assert property (start_i && !busy_o |=> busy_o)
      else $error("start not taken");
   done_pulse_a: assert property (done_o |=> !done_o)
      else $error("done longer than one cycle");
   done_result_a: assert property (done_o |-> result_o != flash_status_pkg::RESULT_NONE)
      else $error("done without result");
   ready_copy_a: assert property (!$past(reset_i) |-> device_ready_o == $past(ready_busy_output_i))
      else $error("ready copy wrong");
   reset_cmd_a: assert property (!flash_write_n_o |-> flash_data_oe_o && flash_data_o == 16'h00F0)
      else $error("bad reset command write");
   strobe_len_a: assert property ($fell(flash_out_en_n_o) |-> !flash_out_en_n_o [*3] ##1 flash_out_en_n_o)
      else $error("read strobe length wrong");
   gap_len_a: assert property ($rose(flash_chip_sel_n_o) |-> flash_chip_sel_n_o [*2])
      else $error("recovery gap too short");
   read_addr_a: assert property (!flash_out_en_n_o |-> flash_addr_o == status_addr_i)
      else $error("status read at wrong address");
   idle_quiet_a: assert property (!busy_o && !done_o |-> flash_chip_sel_n_o && flash_write_n_o)
      else $error("bus active while idle");
   cover property (done_o && result_o == flash_status_pkg::RESULT_DONE);
   cover property (done_o && result_o == flash_status_pkg::RESULT_FAIL);
   cover property (!flash_write_n_o);
endmodule
bind flash_status_poller flash_poller_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (
   .clk_i(clk_i), .reset_i(reset_i), .start_i(start_i), .status_addr_i(status_addr_i),
   .busy_o(busy_o), .done_o(done_o), .result_o(result_o), .device_ready_o(device_ready_o),
   .flash_addr_o(flash_addr_o), .flash_chip_sel_n_o(flash_chip_sel_n_o),
   .flash_out_en_n_o(flash_out_en_n_o), .flash_write_n_o(flash_write_n_o),
   .flash_data_o(flash_data_o), .flash_data_oe_o(flash_data_oe_o),
   .ready_busy_output_i(ready_busy_output_i));

// ### flash_dev_model.sv
// Behavioural flash device answering status reads
module flash_dev_model (
   input wire logic chip_sel_n_i,
   input wire logic out_en_n_i,
   input wire logic write_n_i,
   input wire logic [15:0] host_data_i,
   input wire logic load_i,
   input wire logic erase_i,
   input wire logic sector_i,
   input wire logic [15:0] word_i,
   input wire logic [31:0] busy_reads_i,
   input wire logic [31:0] tmo_reads_i,
   input wire logic suspend_i,
   output logic [15:0] data_o,
   output logic ready_busy_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] left = 32'h0;
   logic [31:0] cnt = 32'h0;
   logic tog = 1'b0;
   logic stog = 1'b0;
   logic [15:0] last = 16'h0000;
   wire rd = !chip_sel_n_i && !out_en_n_i;
   wire busy = left != 32'h0;
   // Suspended erase keeps its sector marked but stops the algorithm
   wire active = busy && !suspend_i;
   wire tmo = active && cnt >= tmo_reads_i;
   // status word; polling bit reads 1 in erase suspend
   wire [15:0] stat = {word_i[15:8], erase_i ? suspend_i : ~word_i[7], tog, tmo, word_i[4:3],
                       sector_i & stog, word_i[1:0]};
   assign data_o = rd ? (busy ? stat : word_i) : ~last;
   // open drain pulled high when released or suspended
   assign ready_busy_o = active ? 1'b0 : 1'b1;
   // status for a loaded span of reads, then array data unchanged
   always @(posedge load_i) begin
      left = busy_reads_i;
      cnt = 32'h0;
   end
   // advance once per completed read; toggle bit only while running, sector toggle bit whenever busy
   always @(negedge rd) begin
      last = busy ? stat : word_i;
      if (busy) stog = ~stog;
      if (active) begin
         tog = ~tog;
         cnt = cnt + 1;
         left = left - 1;
      end
   end
   always @(posedge write_n_i) if (host_data_i == 16'h00F0) left = 32'h0;
endmodule

// ### tb_top.sv
// Testbench driving the status poller against the device model
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic start = 1'b0;
   logic abandon = 1'b0;
   logic load = 1'b0;
   logic erase = 1'b0;
   logic sector = 1'b0;
   logic saw_low = 1'b0;
   logic suspend = 1'b0;
   flash_status_pkg::poll_mode_t mode = flash_status_pkg::MODE_TOGGLE;
   logic [22:0] addr = 23'h012345;
   logic [15:0] word = 16'h0000;
   logic [31:0] br = 32'h0;
   logic [31:0] tr = 32'h0;
   logic busy, done, sec, rdy, cs_n, oe_n, we_n, d_oe, rb;
   flash_status_pkg::result_t res;
   logic [15:0] fin, d_out, d_in;
   logic [22:0] f_addr;
   int num_errors = 0;
   int samples_checked = 0;
   always #10 clk_i = ~clk_i;
   flash_status_poller u_flash_status_poller (.clk_i(clk_i), .reset_i(reset_i), .start_i(start),
      .abandon_i(abandon), .mode_i(mode), .status_addr_i(addr), .expect_data_i(word),
      .busy_o(busy), .done_o(done), .result_o(res), .final_data_o(fin), .sector_erasing_o(sec),
      .device_ready_o(rdy), .flash_addr_o(f_addr), .flash_chip_sel_n_o(cs_n),
      .flash_out_en_n_o(oe_n), .flash_write_n_o(we_n), .flash_data_o(d_out),
      .flash_data_oe_o(d_oe), .flash_data_i(d_in), .ready_busy_output_i(rb));
   flash_dev_model u_flash_dev_model (.chip_sel_n_i(cs_n), .out_en_n_i(oe_n), .write_n_i(we_n),
      .host_data_i(d_out), .load_i(load), .erase_i(erase), .sector_i(sector), .word_i(word),
      .busy_reads_i(br), .tmo_reads_i(tr), .suspend_i(suspend), .data_o(d_in),
      .ready_busy_o(rb));
   task finish_test;
      if (num_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task check(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) begin
         $display("[ERR] %0t %s", $time, m);
         num_errors++;
      end
   endtask
   // Lets the report cycle pass, then loads the model and starts one check
   task launch(input flash_status_pkg::poll_mode_t m, input logic [15:0] w, input int b,
               input int t, input logic e);
      int i;
      @(negedge clk_i);
      for (i = 0; i < 8 && busy !== 1'b0; i++) @(negedge clk_i);
      mode = m;
      word = w;
      br = b;
      tr = t;
      erase = e;
      load = 1'b1;
      start = 1'b1;
      saw_low = 1'b0;
      @(negedge clk_i);
      start = 1'b0;
      load = 1'b0;
   endtask
   // Waits for the done pulse; a missing one ends the run
   task wait_done;
      int i;
      for (i = 0; i < 3000 && done !== 1'b1; i++) begin
         @(posedge clk_i);
         #1;
         if (rdy === 1'b0) saw_low = 1'b1;
      end
      check(done === 1'b1, "no done");
      if (done !== 1'b1) finish_test();
   endtask
   // Starts one check and compares its outcome
   task run(input flash_status_pkg::poll_mode_t m, input logic [15:0] w, input int b,
            input int t, input logic e, input flash_status_pkg::result_t exp);
      launch(m, w, b, t, e);
      wait_done();
      check(res === exp, "result wrong");
      check(exp != flash_status_pkg::RESULT_DONE || fin === w, "final word wrong");
   endtask
   initial begin
      int i;
      repeat (20) @(negedge clk_i);
      reset_i = 1'b0;
      run(flash_status_pkg::MODE_TOGGLE, 16'hA5C3, 0, 100, 1'b0, flash_status_pkg::RESULT_DONE);
      run(flash_status_pkg::MODE_TOGGLE, 16'h3C5A, 6, 100, 1'b0, flash_status_pkg::RESULT_DONE);
      check(saw_low === 1'b1, "busy line never seen");
      run(flash_status_pkg::MODE_TOGGLE, 16'h0F0F, 99999, 2, 1'b0, flash_status_pkg::RESULT_FAIL);
      repeat (3) @(negedge clk_i);
      check(rdy === 1'b1, "device not released after abort");
      run(flash_status_pkg::MODE_POLL, 16'h1234, 4, 100, 1'b0, flash_status_pkg::RESULT_DONE);
      run(flash_status_pkg::MODE_POLL, 16'hFFFF, 4, 100, 1'b1, flash_status_pkg::RESULT_DONE);
      run(flash_status_pkg::MODE_POLL, 16'h0081, 99999, 2, 1'b0, flash_status_pkg::RESULT_FAIL);
      // Drop monitoring of a long erase, then start over
      sector = 1'b1;
      abandon = 1'b1;
      launch(flash_status_pkg::MODE_TOGGLE, 16'hFFFF, 99999, 99999, 1'b1);
      for (i = 0; i < 500 && !(busy === 1'b0 && i > 2); i++) begin
         @(negedge clk_i);
         check(done !== 1'b1, "done after abandon");
      end
      check(busy === 1'b0, "abandon ignored");
      check(sec === 1'b1, "sector toggle not seen");
      abandon = 1'b0;
      // Erase suspended: toggle bit frozen, sector bit still moving, line released
      suspend = 1'b1;
      launch(flash_status_pkg::MODE_TOGGLE, 16'hFFFF, 99999, 100, 1'b1);
      wait_done();
      check(res === flash_status_pkg::RESULT_DONE, "suspend not seen as stopped");
      check(sec === 1'b1, "suspended sector not marked");
      check(saw_low === 1'b0, "busy line low in suspend");
      suspend = 1'b0;
      run(flash_status_pkg::MODE_TOGGLE, 16'hFFFF, 2, 100, 1'b1, flash_status_pkg::RESULT_DONE);
      finish_test();
   end
endmodule
